//--- iram_pkg.sv
// Constants and types of the remote address remap block
// Operation
// [R1] Bridge address in bits 7:1; bridge alias traffic is rewritten to it.
// [R2] After lock, the forward channel identifier loads the bridge address.
// [R3] Bit 0 set holds auto-loading off; bit 0 clear allows it.
// [R4] Software writing the bridge address also sets the hold bit; the code loads bit 0 from the written data.
// [R5] Zero bridge address or zero bridge alias blocks the bridge alias.
// [R6] Bridge alias traffic is accepted and remapped; alias resets to 0x00.
// [R7] Target 0 address in bits 7:1, reset 0x00; alias 0 traffic goes to it.
// [R8] Target 1 address in bits 7:1, reset 0x00; alias 1 traffic goes to it.
// [R9] A zero target 0 address disables access through alias 0.
// [R10] A zero target 1 address disables access through alias 1.
// [R11] Configuration bit 3 enables forwarding when 1, disables it when 0.
// [R12] With auto acknowledge on, remote writes are acknowledged at once.
// [R13] Start bytes match every nonzero alias; the direction bit is kept.
package iram_pkg;

    localparam logic [7:0] GEN_CONFIG_OFFSET     = 8'h03;
    localparam logic [7:0] REMOTE_BRIDGE_OFFSET  = 8'h06;
    localparam logic [7:0] BRIDGE_ALIAS_OFFSET   = 8'h07;
    localparam logic [7:0] TARGET0_OFFSET        = 8'h08;
    localparam logic [7:0] TARGET1_OFFSET        = 8'h09;
    localparam logic [7:0] TARGET0_ALIAS_OFFSET  = 8'h10;
    localparam logic [7:0] TARGET1_ALIAS_OFFSET  = 8'h11;
    localparam logic [7:0] STATUS_OFFSET         = 8'h12;

    localparam logic [7:0] GEN_CONFIG_RESET      = 8'hE9;
    localparam logic [7:0] REMOTE_BRIDGE_RESET   = 8'h00;
    localparam logic [7:0] BRIDGE_ALIAS_RESET    = 8'h00;
    localparam logic [7:0] TARGET_RESET          = 8'h00;
    localparam logic [7:0] TARGET_ALIAS_RESET    = 8'h00;

    localparam int unsigned PASS_THROUGH_BIT     = 3;
    localparam int unsigned AUTO_ACK_BIT         = 2;
    localparam int unsigned HOLD_AUTO_ID_BIT     = 0;
    localparam int unsigned ADDR_MSB             = 7;
    localparam int unsigned ADDR_LSB             = 1;

    localparam int unsigned ENTRY_COUNT          = 3;
    localparam logic [1:0]  ENTRY_BRIDGE         = 2'h0;
    localparam logic [1:0]  ENTRY_TARGET0        = 2'h1;
    localparam logic [1:0]  ENTRY_TARGET1        = 2'h2;
    localparam logic [1:0]  ENTRY_NONE           = 2'h3;

    localparam logic [3:0]  BYTE_BITS            = 4'h8;
    localparam int unsigned SYNC_WIDTH           = 4;

    typedef enum logic [1:0] {
        IRAM_IDLE = 2'b00,
        IRAM_ADDR = 2'b01,
        IRAM_ACK  = 2'b10,
        IRAM_BUSY = 2'b11
    } iram_state_type;

endpackage

//--- iram_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module iram_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

//--- iram_match.sv
// Alias table lookup: finds the remote address for a local start byte
`timescale 1ns/10ps
module iram_match (
    input  wire logic [6:0] addr_i,
    input  wire logic [6:0] bridge_alias_i,
    input  wire logic [6:0] bridge_addr_i,
    input  wire logic [6:0] target0_alias_i,
    input  wire logic [6:0] target0_addr_i,
    input  wire logic [6:0] target1_alias_i,
    input  wire logic [6:0] target1_addr_i,
    output logic            hit_o,
    output logic [1:0]      entry_o,
    output logic [6:0]      remote_o
);
    logic [6:0] alias_tab  [iram_pkg::ENTRY_COUNT];
    logic [6:0] remote_tab [iram_pkg::ENTRY_COUNT];
    logic [iram_pkg::ENTRY_COUNT-1:0] entry_hit;

    assign alias_tab[0]  = bridge_alias_i;
    assign remote_tab[0] = bridge_addr_i;
    assign alias_tab[1]  = target0_alias_i;
    assign remote_tab[1] = target0_addr_i;
    assign alias_tab[2]  = target1_alias_i;
    assign remote_tab[2] = target1_addr_i;

    // Zero alias or zero remote address disables the entry
    for (genvar e = 0; e < iram_pkg::ENTRY_COUNT; e++) begin : g_entry
        assign entry_hit[e] = (alias_tab[e] != 7'h00)  // [R13]
                            && (remote_tab[e] != 7'h00) // [R5]
                            && (alias_tab[e] == addr_i);
    end

    // Lowest entry wins if two aliases are equal
    always_comb begin
        hit_o    = 1'b0;
        entry_o  = iram_pkg::ENTRY_NONE;
        remote_o = 7'h00;
        for (int e = iram_pkg::ENTRY_COUNT - 1; e >= 0; e--) begin
            if (entry_hit[e]) begin
                hit_o    = 1'b1;
                entry_o  = 2'(e);
                remote_o = remote_tab[e]; // [R1]
            end
        end
    end
endmodule

//--- iram_remap.sv
// Remote address remap: registers, local bus watcher, forwarding
`timescale 1ns/10ps
module iram_remap (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    output logic      [7:0] reg_rdata_o,
    // Local control bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Forward channel and link status
    input  wire logic       rx_lock_i,
    input  wire logic       fwd_id_valid_i,
    input  wire logic [6:0] fwd_id_i,
    input  wire logic       remote_ack_i,
    // Remapped start byte towards the control channel
    output logic      [7:0] fwd_byte_o,
    output logic            fwd_valid_o,
    output logic      [1:0] fwd_entry_o
);
    // Registers
    logic [7:0] gen_config;
    logic [7:0] remote_bridge_address;
    logic [7:0] bridge_alias_address;
    logic [7:0] remote_target0_address;
    logic [7:0] remote_target1_address;
    logic [7:0] target0_alias;
    logic [7:0] target1_alias;

    // Synchronised pins
    logic [iram_pkg::SYNC_WIDTH-1:0] pins_async;
    logic [iram_pkg::SYNC_WIDTH-1:0] pins_sync;
    logic       scl_s;
    logic       sda_s;
    logic       lock_s;
    logic       scl_d;
    logic       sda_d;

    // Bus watcher
    iram_pkg::iram_state_type state;
    iram_pkg::iram_state_type next_state;
    logic [7:0] shift;
    logic [3:0] bit_count;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       byte_done;
    logic       hit;
    logic [1:0] entry;
    logic [6:0] remote_addr;
    logic       accept;
    logic       local_ack;
    logic       give_ack;
    logic       pass_through;
    logic       auto_ack;
    logic       hold_auto_id;
    logic       auto_load;

    assign pass_through = gen_config[iram_pkg::PASS_THROUGH_BIT];
    assign auto_ack     = gen_config[iram_pkg::AUTO_ACK_BIT];
    assign hold_auto_id = remote_bridge_address[iram_pkg::HOLD_AUTO_ID_BIT];

    // Bus pins enter inverted so the synchroniser resets to idle high
    assign pins_async = {~scl_i, ~sda_i, rx_lock_i, 1'b0};

    iram_sync #(
        .WIDTH (iram_pkg::SYNC_WIDTH)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (pins_async),
        .sync_o  (pins_sync)
    );

    assign scl_s  = ~pins_sync[3];
    assign sda_s  = ~pins_sync[2];
    assign lock_s = pins_sync[1];

    // Idle bus level is high on both lines
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise   = scl_s && !scl_d;
    assign scl_fall   = !scl_s && scl_d;
    assign start_seen = scl_s && scl_d && sda_d && !sda_s;
    assign stop_seen  = scl_s && scl_d && !sda_d && sda_s;
    assign byte_done  = (bit_count == iram_pkg::BYTE_BITS);

    iram_match u_match (
        .addr_i          (shift[7:1]),
        .bridge_alias_i  (bridge_alias_address[7:1]),
        .bridge_addr_i   (remote_bridge_address[7:1]),
        .target0_alias_i (target0_alias[7:1]),
        .target0_addr_i  (remote_target0_address[7:1]),
        .target1_alias_i (target1_alias[7:1]),
        .target1_addr_i  (remote_target1_address[7:1]),
        .hit_o           (hit),
        .entry_o         (entry),
        .remote_o        (remote_addr)
    );

    assign accept    = pass_through && hit; // [R11]
    // Writes acknowledged locally without waiting for the far end
    assign local_ack = auto_ack && !shift[0]; // [R12]
    assign give_ack  = accept && (local_ack || remote_ack_i);

    // Forward channel identifier load after lock
    assign auto_load = lock_s && fwd_id_valid_i && !hold_auto_id; // [R2] [R3]

    // Register writes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gen_config <= iram_pkg::GEN_CONFIG_RESET;
        end else if (reg_write_i
                     && reg_addr_i == iram_pkg::GEN_CONFIG_OFFSET) begin
            gen_config <= reg_wdata_i;
        end
    end

    // Software write wins over a load in the same cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            remote_bridge_address <= iram_pkg::REMOTE_BRIDGE_RESET;
        end else if (reg_write_i
                     && reg_addr_i == iram_pkg::REMOTE_BRIDGE_OFFSET) begin
            remote_bridge_address <= reg_wdata_i; // [R1] [R4]
        end else if (auto_load) begin
            remote_bridge_address[7:1] <= fwd_id_i; // [R2]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bridge_alias_address <= iram_pkg::BRIDGE_ALIAS_RESET; // [R6]
        end else if (reg_write_i
                     && reg_addr_i == iram_pkg::BRIDGE_ALIAS_OFFSET) begin
            bridge_alias_address <= {reg_wdata_i[7:1], 1'b0};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            remote_target0_address <= iram_pkg::TARGET_RESET; // [R7]
            remote_target1_address <= iram_pkg::TARGET_RESET; // [R8]
        end else if (reg_write_i) begin
            if (reg_addr_i == iram_pkg::TARGET0_OFFSET) begin
                remote_target0_address <= {reg_wdata_i[7:1], 1'b0};
            end
            if (reg_addr_i == iram_pkg::TARGET1_OFFSET) begin
                remote_target1_address <= {reg_wdata_i[7:1], 1'b0};
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            target0_alias <= iram_pkg::TARGET_ALIAS_RESET;
            target1_alias <= iram_pkg::TARGET_ALIAS_RESET;
        end else if (reg_write_i) begin
            if (reg_addr_i == iram_pkg::TARGET0_ALIAS_OFFSET) begin
                target0_alias <= {reg_wdata_i[7:1], 1'b0};
            end
            if (reg_addr_i == iram_pkg::TARGET1_ALIAS_OFFSET) begin
                target1_alias <= {reg_wdata_i[7:1], 1'b0};
            end
        end
    end

    // Register reads, data in the following cycle only
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            unique case (reg_addr_i)
                iram_pkg::GEN_CONFIG_OFFSET:
                    reg_rdata_o <= gen_config;
                iram_pkg::REMOTE_BRIDGE_OFFSET:
                    reg_rdata_o <= remote_bridge_address;
                iram_pkg::BRIDGE_ALIAS_OFFSET:
                    reg_rdata_o <= bridge_alias_address;
                iram_pkg::TARGET0_OFFSET:
                    reg_rdata_o <= remote_target0_address;
                iram_pkg::TARGET1_OFFSET:
                    reg_rdata_o <= remote_target1_address;
                iram_pkg::TARGET0_ALIAS_OFFSET:
                    reg_rdata_o <= target0_alias;
                iram_pkg::TARGET1_ALIAS_OFFSET:
                    reg_rdata_o <= target1_alias;
                iram_pkg::STATUS_OFFSET:
                    reg_rdata_o <= {3'h0, lock_s, state, fwd_entry_o};
                default:
                    reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Bus watcher state
    always_comb begin
        next_state = state;
        unique case (state)
            iram_pkg::IRAM_IDLE: begin
                if (start_seen) begin
                    next_state = iram_pkg::IRAM_ADDR;
                end
            end
            iram_pkg::IRAM_ADDR: begin
                if (byte_done && scl_fall) begin
                    next_state = give_ack ? iram_pkg::IRAM_ACK
                                          : iram_pkg::IRAM_BUSY;
                end
            end
            iram_pkg::IRAM_ACK: begin
                if (scl_fall) begin
                    next_state = iram_pkg::IRAM_BUSY;
                end
            end
            iram_pkg::IRAM_BUSY: begin
                next_state = iram_pkg::IRAM_BUSY;
            end
        endcase
        if (stop_seen) begin
            next_state = iram_pkg::IRAM_IDLE;
        end else if (start_seen) begin
            next_state = iram_pkg::IRAM_ADDR;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= iram_pkg::IRAM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Start byte shifter, MSB first on rising clock
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            shift     <= 8'h00;
            bit_count <= 4'h0;
        end else if (start_seen) begin
            shift     <= 8'h00;
            bit_count <= 4'h0;
        end else if (state == iram_pkg::IRAM_ADDR && scl_rise
                     && !byte_done) begin
            shift     <= {shift[6:0], sda_s};
            bit_count <= bit_count + 4'h1;
        end
    end

    // Remapped byte towards the control channel, one pulse per accepted match
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fwd_byte_o  <= 8'h00;
            fwd_valid_o <= 1'b0;
            fwd_entry_o <= iram_pkg::ENTRY_NONE;
        end else begin
            fwd_valid_o <= 1'b0;
            if (state == iram_pkg::IRAM_ADDR && byte_done && scl_fall) begin
                if (accept) begin
                    fwd_byte_o  <= {remote_addr, shift[0]}; // [R13] [R6]
                    fwd_valid_o <= 1'b1; // [R7] [R8]
                    fwd_entry_o <= entry;
                end else begin
                    fwd_entry_o <= iram_pkg::ENTRY_NONE; // [R9] [R10]
                end
            end
        end
    end

    // Acknowledge drive on the ninth clock
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o    <= 1'b1;
            sda_oe_o <= 1'b0;
        end else if (state == iram_pkg::IRAM_ADDR && byte_done && scl_fall
                     && give_ack && !stop_seen && !start_seen) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b1; // [R12]
        end else if (state != iram_pkg::IRAM_ACK || scl_fall) begin
            sda_o    <= 1'b1;
            sda_oe_o <= 1'b0;
        end
    end
endmodule

//--- iram_remap_asserts.sv
// Port checker for the remote address remap block
`timescale 1ns/10ps
module iram_remap_asserts (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_read_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic       sda_o,
    input  wire logic       sda_oe_o,
    input  wire logic [7:0] fwd_byte_o,
    input  wire logic       fwd_valid_o,
    input  wire logic [1:0] fwd_entry_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ack_on;
        $rose(sda_oe_o);
    endsequence
    sequence s_ack_off;
        !sda_oe_o;
    endsequence
    sequence s_fwd_pulse;
        fwd_valid_o ##1 !fwd_valid_o;
    endsequence

    a_rdata_idle: assert property (
        !$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    a_resv_bit: assert property (
        reg_read_i && reg_addr_i inside {8'h07, 8'h08, 8'h09}
        |=> reg_rdata_o[0] == 1'b0)
        else $error("reserved bit 0 reads one");
    a_valid_pulse: assert property (
        fwd_valid_o |-> s_fwd_pulse)
        else $error("forward valid longer than one cycle");
    a_byte_hold: assert property (
        !fwd_valid_o |-> $stable(fwd_byte_o))
        else $error("forward byte changed without valid");
    a_entry_none: assert property (
        !fwd_valid_o && $changed(fwd_entry_o) |-> fwd_entry_o == 2'h3)
        else $error("entry changed to a target without valid");
    a_valid_entry: assert property (
        fwd_valid_o |-> fwd_entry_o != 2'h3)
        else $error("forward valid with no entry");
    a_zero_block: assert property (
        fwd_valid_o |-> fwd_byte_o[7:1] != 7'h00)
        else $error("forwarded to zero address");
    a_ack_level: assert property (
        sda_oe_o |-> !sda_o)
        else $error("data pin driven high");
    a_ack_start: assert property (
        s_ack_on |-> fwd_valid_o)
        else $error("ack without forwarded byte");
    a_ack_bound: assert property (
        s_ack_on |-> ##[1:200] s_ack_off)
        else $error("ack never released");
endmodule

bind iram_remap iram_remap_asserts i_chk (.clock_i(clock_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .fwd_byte_o(fwd_byte_o), .fwd_valid_o(fwd_valid_o),
    .fwd_entry_o(fwd_entry_o));

//--- iram_host_model.sv
// Local bus controller model sending one start byte a frame
`timescale 1ns/10ps
module iram_host_model (
    input  wire logic clock_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Start, byte, ninth clock, stop; hp cycles a half phase
    task automatic xfer(input logic [7:0] b, input int hp, output logic ack);
        sda_o <= 1'b0;
        hold(hp);
        scl_o <= 1'b0;
        hold(1);
        for (int i = 7; i >= 0; i--) begin
            sda_o <= b[i];
            hold(hp - 1);
            scl_o <= 1'b1;
            hold(hp);
            scl_o <= 1'b0;
            hold(1);
        end
        sda_o <= 1'b1;
        hold(hp - 1);
        scl_o <= 1'b1;
        hold(hp);
        ack = sda_i;
        scl_o <= 1'b0;
        hold(hp);
        sda_o <= 1'b0;
        hold(hp);
        scl_o <= 1'b1;
        hold(hp);
        sda_o <= 1'b1;
        hold(hp);
    endtask
endmodule

//--- tb_iram_remap.sv
// Testbench for the remote address remap block
`timescale 1ns/10ps
module tb_iram_remap;
    logic       clock_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_write_i = 1'b0;
    logic       reg_read_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       scl;
    logic       host_sda;
    logic       sda_o;
    logic       sda_oe_o;
    logic       rx_lock_i = 1'b0;
    logic       fwd_id_valid_i = 1'b0;
    logic [6:0] fwd_id_i = 7'h00;
    logic       remote_ack_i = 1'b0;
    logic [7:0] fwd_byte_o;
    logic [7:0] got_byte;
    logic       fwd_valid_o;
    logic [1:0] fwd_entry_o;
    int         bad_count = 0;
    int         num_checks = 0;
    int         pulses = 0;
    int         cycles = 0;
    wire        sda_bus = host_sda & ~(sda_oe_o & ~sda_o);

    always #25 clock_i = ~clock_i;

    iram_remap i_dut (.clock_i(clock_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .scl_i(scl), .sda_i(sda_bus),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rx_lock_i(rx_lock_i),
        .fwd_id_valid_i(fwd_id_valid_i), .fwd_id_i(fwd_id_i),
        .remote_ack_i(remote_ack_i), .fwd_byte_o(fwd_byte_o),
        .fwd_valid_o(fwd_valid_o), .fwd_entry_o(fwd_entry_o));
    iram_host_model i_host (.clock_i(clock_i), .sda_i(sda_bus),
        .scl_o(scl), .sda_o(host_sda));

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (fwd_valid_o === 1'b1) begin
            pulses <= pulses + 1;
            got_byte <= fwd_byte_o;
        end
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        @(negedge clock_i);
        chk(reg_rdata_o, exp);
    endtask
    task automatic load_id(input logic [6:0] id);
        @(posedge clock_i);
        fwd_id_i <= id;
        fwd_id_valid_i <= 1'b1;
        @(posedge clock_i);
        fwd_id_valid_i <= 1'b0;
    endtask
    // One start byte; expected byte, entry and ack level
    task automatic frame(input logic [7:0] b, input int hp,
        input logic [7:0] eb, input logic [1:0] ee, input logic ea);
        int   p0;
        logic ack;
        p0 = pulses;
        @(posedge clock_i);
        i_host.xfer(b, hp, ack);
        chk(8'(pulses - p0), {7'h00, ee != 2'h3});
        if (ee != 2'h3)
            chk(got_byte, eb);
        chk({6'h00, fwd_entry_o}, {6'h00, ee});
        chk({7'h00, ack}, {7'h00, ea});
    endtask

    task automatic t_regs();
        logic [7:0] a[9];
        logic [7:0] e[9];
        a = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h05, 8'h12};
        e = '{8'hE9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
        foreach (a[i]) begin
            rc(a[i], e[i]);
        end
        wr(8'h07, 8'hFF);
        rc(8'h07, 8'hFE);
        wr(8'h06, 8'h55);
        rc(8'h06, 8'h55);
        wr(8'h05, 8'hFF);
        rc(8'h05, 8'h00);
        wr(8'h07, 8'h00);
        wr(8'h06, 8'h00);
    endtask
    task automatic t_autoload();
        load_id(7'h11);
        rc(8'h06, 8'h00);
        @(posedge clock_i);
        rx_lock_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        load_id(7'h2A);
        rc(8'h06, 8'h54);
        wr(8'h06, 8'h67);
        load_id(7'h15);
        rc(8'h06, 8'h67);
    endtask
    task automatic t_forward();
        wr(8'h07, 8'h80);
        wr(8'h10, 8'hA0);
        wr(8'h11, 8'hA2);
        wr(8'h08, 8'h42);
        wr(8'h09, 8'h44);
        remote_ack_i <= 1'b1;
        frame(8'h80, 4, 8'h66, 2'h0, 1'b0);
        frame(8'hA1, 4, 8'h43, 2'h1, 1'b0);
        frame(8'hA2, 4, 8'h44, 2'h2, 1'b0);
        frame(8'h90, 4, 8'h00, 2'h3, 1'b1);
    endtask
    task automatic t_refuse();
        wr(8'h08, 8'h00);
        frame(8'hA0, 4, 8'h00, 2'h3, 1'b1);
        wr(8'h09, 8'h00);
        frame(8'hA2, 4, 8'h00, 2'h3, 1'b1);
        wr(8'h06, 8'h01);
        frame(8'h80, 4, 8'h00, 2'h3, 1'b1);
        wr(8'h06, 8'h67);
        wr(8'h03, 8'hE1);
        frame(8'h80, 4, 8'h00, 2'h3, 1'b1);
    endtask
    task automatic t_autoack();
        wr(8'h03, 8'hED);
        remote_ack_i <= 1'b0;
        frame(8'h80, 4, 8'h66, 2'h0, 1'b0);
        frame(8'h81, 4, 8'h67, 2'h0, 1'b1);
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        t_regs();
        t_autoload();
        t_forward();
        t_refuse();
        t_autoack();
        print_verdict();
    end
endmodule
